/* gpio_pkg.sv */
// constants for the grouped i/o port block: register indices, reset
// values, bus response codes and pin group geometry.
// assumes a 32-bit axi4-lite register bus; byte address = 4 * index.
package gpio_pkg;

  localparam int GROUP_COUNT = 4;
  localparam int GROUP_WIDTH = 4;
  localparam int PIN_COUNT = GROUP_COUNT * GROUP_WIDTH;
  localparam int ADDR_W = 14;
  localparam int INDEX_W = 12;
  localparam int REG_COUNT = 6;

  // register indices as printed; byte address is four times these
  localparam logic [INDEX_W-1:0] PIN_GROUP0_DATA = 12'hf60;
  localparam logic [INDEX_W-1:0] PIN_GROUP1_DATA = 12'hf61;
  localparam logic [INDEX_W-1:0] PIN_GROUP2_DATA = 12'hf62;
  localparam logic [INDEX_W-1:0] PIN_GROUP3_DATA = 12'hf63;
  localparam logic [INDEX_W-1:0] GROUP_DIRECTION_CONTROL = 12'hf7d;
  localparam logic [INDEX_W-1:0] GROUP_PULLUP_CONTROL = 12'hf7e;

  // decoder slot order
  localparam int SLOT_DIR = 4;
  localparam int SLOT_PULL = 5;

  localparam logic [INDEX_W-1:0] REG_INDEX [REG_COUNT] = '{
    PIN_GROUP0_DATA, PIN_GROUP1_DATA, PIN_GROUP2_DATA,
    PIN_GROUP3_DATA, GROUP_DIRECTION_CONTROL, GROUP_PULLUP_CONTROL
  };

  localparam logic [3:0] DIRECTION_RESET = 4'h0;
  localparam logic [3:0] PULLUP_OFF_RESET = 4'h0;
  localparam logic [15:0] DATA_RESET = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

/* reg_addr_decode.sv */
// byte address to register slot decoder.
// assumes word-aligned access; the two low address bits are ignored.
`timescale 1ns/1ps
module reg_addr_decode (
  // address in
  input wire logic [gpio_pkg::ADDR_W-1:0] addr,
  // one-hot slot and any-hit
  output logic [gpio_pkg::REG_COUNT-1:0] hit,
  output logic mapped
);

  genvar i;
  generate
    for (i = 0; i < gpio_pkg::REG_COUNT; i = i + 1)
    begin : g_slot
      assign hit[i] = (addr[gpio_pkg::ADDR_W-1:2] == gpio_pkg::REG_INDEX[i]);
    end
  endgenerate

  assign mapped = |hit;

endmodule

/* pin_group_pad.sv */
// pad control for one four-pin group: drive value, driver enable and
// pull-up enable from the group settings and build-time options.
// assumes the pad ring resolves the wire from out, oe and pull_en.
`timescale 1ns/1ps
module pin_group_pad (
  // group settings
  input wire logic dir,
  input wire logic pullup_off,
  input wire logic [3:0] data,
  // build-time options per pin
  input wire logic [3:0] dedicated,
  input wire logic [3:0] ext_sel,
  input wire logic [3:0] open_drain,
  // memory interface drive
  input wire logic [3:0] ext_out,
  input wire logic [3:0] ext_oe,
  // pad controls
  output logic [3:0] pin_out,
  output logic [3:0] pin_oe,
  output logic [3:0] pull_en
);

  genvar b;
  generate
    for (b = 0; b < 4; b = b + 1)
    begin : g_pin
      logic val;
      logic en;
      // memory and dedicated pins do not look at dir
      assign val = ext_sel[b] ? ext_out[b] : data[b];
      assign en = ext_sel[b] ? ext_oe[b] : (dedicated[b] | dir);
      // open drain only sinks; a high is left to the pull-up
      assign pin_out[b] = open_drain[b] ? 1'b0 : val;
      assign pin_oe[b] = open_drain[b] ? (en & ~val) : en;
      assign pull_en[b] = ~pullup_off & ~dedicated[b];
    end
  endgenerate

endmodule

/* grouped_io_port_control.sv */
// grouped i/o port: four 4-pin groups with direction, pull-up and data
// registers behind an axi4-lite slave.
// assumes pin_in is synchronous to aclk and that the pad ring turns
// pin_out, pin_oe and pin_pullup_en into the wire level.
`timescale 1ns/1ps
module grouped_io_port_control #(
  parameter bit HAS_GROUP3 = 1'b1,
  parameter logic [3:0] GROUP3_DEDICATED = 4'h0,
  parameter bit EXT_MEM_DATA = 1'b0,
  parameter logic [3:0] EXT_MEM_CS = 4'h0,
  parameter logic [15:0] OPEN_DRAIN = 16'h0000
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // write address channel
  input wire logic [gpio_pkg::ADDR_W-1:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  // write data channel
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // write response channel
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // read address channel
  input wire logic [gpio_pkg::ADDR_W-1:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  // read data channel
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // pins
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  output logic [15:0] pin_pullup_en,
  // external memory access through groups 0 to 2
  input wire logic [7:0] ext_mem_data_out,
  input wire logic ext_mem_data_oe,
  output logic [7:0] ext_mem_data_in,
  input wire logic [3:0] ext_mem_cs_n
);

  typedef struct packed {
    logic [3:0] dir;
    logic [3:0] pullup_off;
    logic [15:0] data;
    logic aw_got;
    logic [gpio_pkg::ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [3:0] w_data;
    logic w_strb0;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
  } state_s;

  state_s st_reg;
  state_s st_next;

  // group 3 bits vanish in the reduced variant
  localparam logic [3:0] IMPL_MASK = {HAS_GROUP3, 3'b111};
  localparam logic [3:0] DED3 = HAS_GROUP3 ? GROUP3_DEDICATED : 4'h0;
  localparam logic [15:0] DEDICATED = {DED3, 12'h000};
  localparam logic [15:0] EXT_SEL = {4'h0, EXT_MEM_CS, {8{EXT_MEM_DATA}}};
  localparam logic [15:0] GPIO_MASK = ~(DEDICATED | EXT_SEL);

  logic [gpio_pkg::ADDR_W-1:0] wr_addr;
  logic [3:0] wr_data;
  logic wr_strb0;
  logic [gpio_pkg::REG_COUNT-1:0] wr_hit;
  logic wr_mapped;
  logic [gpio_pkg::REG_COUNT-1:0] rd_hit;
  logic rd_mapped;
  logic wr_fire;
  logic rd_fire;
  logic [3:0] eff_dir;
  logic [15:0] dir_pins;
  logic [15:0] ext_out;
  logic [15:0] ext_oe;
  logic [15:0] pin_seen;

  // address and data may arrive in either order; a held one wins
  assign wr_addr = st_reg.aw_got ? st_reg.aw_addr : awaddr;
  assign wr_data = st_reg.w_got ? st_reg.w_data : wdata[3:0];
  assign wr_strb0 = st_reg.w_got ? st_reg.w_strb0 : wstrb[0];

  assign awready = ~st_reg.aw_got & ~st_reg.bvalid;
  assign wready = ~st_reg.w_got & ~st_reg.bvalid;
  assign arready = ~st_reg.rvalid;
  assign wr_fire = (st_reg.aw_got | (awvalid & awready))
                 & (st_reg.w_got | (wvalid & wready))
                 & ~st_reg.bvalid;
  assign rd_fire = arvalid & arready;

  reg_addr_decode u_wr_decode (
    .addr(wr_addr),
    .hit(wr_hit),
    .mapped(wr_mapped)
  );

  reg_addr_decode u_rd_decode (
    .addr(araddr),
    .hit(rd_hit),
    .mapped(rd_mapped)
  );

  // group 3 pins read low when the group does not exist
  assign pin_seen = {pin_in[15:12] & {4{HAS_GROUP3}}, pin_in[11:0]};

  always_comb
  begin
    st_next = st_reg;
    if (st_reg.bvalid && bready)
    begin
      st_next.bvalid = 1'b0;
    end
    if (st_reg.rvalid && rready)
    begin
      st_next.rvalid = 1'b0;
    end
    if (awvalid && awready)
    begin
      st_next.aw_got = 1'b1;
      st_next.aw_addr = awaddr;
    end
    if (wvalid && wready)
    begin
      st_next.w_got = 1'b1;
      st_next.w_data = wdata[3:0];
      st_next.w_strb0 = wstrb[0];
    end
    if (wr_fire)
    begin
      st_next.aw_got = 1'b0;
      st_next.w_got = 1'b0;
      st_next.bvalid = 1'b1;
      st_next.bresp = wr_mapped ? gpio_pkg::RESP_OKAY
                                : gpio_pkg::RESP_SLVERR;
      // only byte lane 0 carries the four implemented bits
      if (wr_strb0)
      begin
        if (wr_hit[gpio_pkg::SLOT_DIR])
        begin
          st_next.dir = wr_data & IMPL_MASK;
        end
        if (wr_hit[gpio_pkg::SLOT_PULL])
        begin
          st_next.pullup_off = wr_data & IMPL_MASK;
        end
        // data is stored whatever the direction holds
        if (wr_hit[0])
        begin
          st_next.data[3:0] = wr_data;
        end
        if (wr_hit[1])
        begin
          st_next.data[7:4] = wr_data;
        end
        if (wr_hit[2])
        begin
          st_next.data[11:8] = wr_data;
        end
        if (wr_hit[3] && HAS_GROUP3)
        begin
          st_next.data[15:12] = wr_data;
        end
      end
    end
    if (rd_fire)
    begin
      st_next.rvalid = 1'b1;
      st_next.rresp = rd_mapped ? gpio_pkg::RESP_OKAY
                                : gpio_pkg::RESP_SLVERR;
      st_next.rdata = 32'h0000_0000;
      // pin level, not the stored bit; an open-drain high with no
      // pull-up floats, so that read is not meaningful
      if (rd_hit[0])
      begin
        st_next.rdata[3:0] = pin_seen[3:0];
      end
      if (rd_hit[1])
      begin
        st_next.rdata[3:0] = pin_seen[7:4];
      end
      if (rd_hit[2])
      begin
        st_next.rdata[3:0] = pin_seen[11:8];
      end
      if (rd_hit[3])
      begin
        st_next.rdata[3:0] = pin_seen[15:12];
      end
      if (rd_hit[gpio_pkg::SLOT_DIR])
      begin
        st_next.rdata[3:0] = st_reg.dir;
      end
      if (rd_hit[gpio_pkg::SLOT_PULL])
      begin
        st_next.rdata[3:0] = st_reg.pullup_off;
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_reg <= '0;
      st_reg.dir <= gpio_pkg::DIRECTION_RESET;
      st_reg.pullup_off <= gpio_pkg::PULLUP_OFF_RESET;
      st_reg.data <= gpio_pkg::DATA_RESET;
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  assign bvalid = st_reg.bvalid;
  assign bresp = st_reg.bresp;
  assign rvalid = st_reg.rvalid;
  assign rresp = st_reg.rresp;
  assign rdata = st_reg.rdata;

  // memory data pins share one enable; chip selects always drive
  assign ext_out = {4'h0, ext_mem_cs_n, ext_mem_data_out};
  assign ext_oe = {4'h0, 4'hf, {8{ext_mem_data_oe}}};
  assign ext_mem_data_in = pin_in[7:0];

  assign eff_dir = st_reg.dir & IMPL_MASK;
  assign dir_pins = {{4{eff_dir[3]}}, {4{eff_dir[2]}},
                     {4{eff_dir[1]}}, {4{eff_dir[0]}}};

  genvar g;
  generate
    for (g = 0; g < gpio_pkg::GROUP_COUNT; g = g + 1)
    begin : g_group
      // group g follows direction and pull-up bit g
      pin_group_pad u_pad (
        .dir(eff_dir[g]),
        .pullup_off(st_reg.pullup_off[g]),
        .data(st_reg.data[4*g +: 4]),
        .dedicated(DEDICATED[4*g +: 4]),
        .ext_sel(EXT_SEL[4*g +: 4]),
        .open_drain(OPEN_DRAIN[4*g +: 4]),
        .ext_out(ext_out[4*g +: 4]),
        .ext_oe(ext_oe[4*g +: 4]),
        .pin_out(pin_out[4*g +: 4]),
        .pin_oe(pin_oe[4*g +: 4]),
        .pull_en(pin_pullup_en[4*g +: 4])
      );
    end
  endgenerate

  dir_after_reset_a: assert property (@(posedge aclk)
    !aresetn |=> st_reg.dir == 4'h0 && pin_oe == 16'h0000 ||
      DEDICATED != 16'h0000 || EXT_SEL != 16'h0000)
    else $error("direction not cleared by reset");

  pull_after_reset_a: assert property (@(posedge aclk)
    !aresetn |=> st_reg.pullup_off == 4'h0)
    else $error("pull-ups not enabled by reset");

  input_hiz_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pin_oe & GPIO_MASK & ~dir_pins) == 16'h0000)
    else $error("input group pin is driven");

  output_drive_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    ((pin_oe ^ dir_pins) & GPIO_MASK & ~OPEN_DRAIN) == 16'h0000 &&
    ((pin_out ^ st_reg.data) & GPIO_MASK & ~OPEN_DRAIN & dir_pins)
      == 16'h0000)
    else $error("output group pin not following data");

  dedicated_drive_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    ((~pin_oe | (pin_out ^ st_reg.data)) & DEDICATED & ~OPEN_DRAIN)
      == 16'h0000 && (pin_pullup_en & DEDICATED) == 16'h0000)
    else $error("dedicated pin not driving data or pulled up");

  pull_map_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pin_pullup_en[3:0] == {4{~st_reg.pullup_off[0]}} &&
    pin_pullup_en[11:8] == {4{~st_reg.pullup_off[2]}})
    else $error("pull-up enable does not follow its group bit");

  dir_write_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wr_fire && wr_strb0 && wr_hit[gpio_pkg::SLOT_DIR] |=>
      st_reg.dir == ($past(wr_data) & IMPL_MASK) && bvalid ##0
      bresp == gpio_pkg::RESP_OKAY)
    else $error("direction write not applied");

  data_hold_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wr_fire && wr_strb0 && wr_hit[1] ##1 !wr_fire [*2] |->
      st_reg.data[7:4] == $past(wr_data, 2))
    else $error("data write lost");

  pin_read_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rd_fire && rd_hit[2] |=> rvalid && rdata[3:0] == $past(pin_in[11:8])
      && rdata[31:4] == 28'h000_0000)
    else $error("data read not showing pin level");

  group3_absent_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    !HAS_GROUP3 |-> st_reg.dir[3] == 1'b0 && st_reg.pullup_off[3] == 1'b0
      && pin_oe[15:12] == 4'h0)
    else $error("missing group 3 shows state");

  resp_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped before taken");

  late_effect_a: assert property (@(posedge aclk)
    disable iff (!aresetn)
    wr_fire && wr_strb0 && wr_hit[gpio_pkg::SLOT_PULL] |->
      st_reg.pullup_off == $past(st_reg.pullup_off) || $past(wr_fire))
    else $error("pull-up register changed before write completed");

endmodule

/* pin_pad_model.sv */
// board-side model of the sixteen port pins: resolves each wire level.
// assumes board drivers are never enabled on a pin the device drives.
`timescale 1ns/1ps
module pin_pad_model (
  // clock
  input wire logic aclk,
  // device pad controls
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] pin_pullup_en,
  // board drive
  input wire logic [15:0] ext_drv,
  input wire logic [15:0] ext_en,
  // resolved wire level
  output logic [15:0] pin_level
);
  logic [15:0] float_reg = 16'h5a5a;

  // a floating pin wanders so a stale read can never pass by luck
  always_ff @(posedge aclk)
  begin
    float_reg <= ~float_reg;
  end

  always_comb
  begin
    for (int i = 0; i < 16; i++)
    begin
      if (pin_oe[i])
        pin_level[i] = pin_out[i];
      else if (ext_en[i])
        pin_level[i] = ext_drv[i];
      else if (pin_pullup_en[i])
        pin_level[i] = 1'b1;
      else
        pin_level[i] = float_reg[i];
    end
  end
endmodule

/* tb.sv */
// self-checking bench for the grouped i/o port over axi4-lite.
// assumes default build options: four groups, no memory or dedicated pins.
`timescale 1ns/1ps
module tb;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [13:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic [31:0] wdata = '0;
  logic [3:0] wstrb = 4'hf;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic [13:0] araddr = '0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic [15:0] pin_in, pin_out, pin_oe, pin_pullup_en;
  logic [15:0] ext_drv = '0;
  logic [15:0] ext_en = '0;
  logic [7:0] mem_in;
  int num_errors = 0;
  int check_count = 0;

  initial
  begin
    forever #12.5 aclk = ~aclk;
  end

  grouped_io_port_control dut_u (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en),
    .ext_mem_data_out(8'h00), .ext_mem_data_oe(1'b0),
    .ext_mem_data_in(mem_in), .ext_mem_cs_n(4'hf)
  );

  pin_pad_model pads_u (
    .aclk(aclk), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .ext_drv(ext_drv), .ext_en(ext_en),
    .pin_level(pin_in)
  );

  // option builds shadow every bus transfer so that their own assertions
  // see real traffic; their handshakes match dut_u, which answers alone
  grouped_io_port_control #(
    .HAS_GROUP3(1'b0)
  ) small_u (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(),
    .bresp(), .bvalid(), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(),
    .rdata(), .rresp(), .rvalid(), .rready(rready),
    .pin_in(pin_in), .pin_out(), .pin_oe(), .pin_pullup_en(),
    .ext_mem_data_out(8'h00), .ext_mem_data_oe(1'b0),
    .ext_mem_data_in(), .ext_mem_cs_n(4'hf)
  );

  grouped_io_port_control #(
    .GROUP3_DEDICATED(4'hf),
    .EXT_MEM_DATA(1'b1),
    .EXT_MEM_CS(4'h5)
  ) opt_u (
    .aclk(aclk), .aresetn(aresetn),
    .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid), .awready(),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(),
    .bresp(), .bvalid(), .bready(bready),
    .araddr(araddr), .arprot(3'h0), .arvalid(arvalid), .arready(),
    .rdata(), .rresp(), .rvalid(), .rready(rready),
    .pin_in(pin_in), .pin_out(), .pin_oe(), .pin_pullup_en(),
    .ext_mem_data_out(8'h00), .ext_mem_data_oe(1'b0),
    .ext_mem_data_in(), .ext_mem_cs_n(4'hf)
  );

  function automatic logic [13:0] adr(input logic [11:0] idx);
    return {idx, 2'b00};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ready and valid are sampled half a cycle ahead, when they are settled
  task automatic wr(input logic [13:0] a, input logic [31:0] d,
                    output logic [1:0] r);
    bit ta, tw, done;
    int n;
    done = 0;
    n = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done && n < 100)
    begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      done = bvalid;
      r = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (done) bready <= 1'b0;
      n++;
    end
    if (!done) chk(32'h0000_0000, 32'h0000_0001);
  endtask

  task automatic rd(input logic [13:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    bit ta, done;
    int n;
    done = 0;
    n = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done && n < 100)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      done = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (done) rready <= 1'b0;
      n++;
    end
    if (!done) chk(32'h0000_0000, 32'h0000_0002);
  endtask

  task automatic rd_chk(input logic [11:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    logic [1:0] r;
    rd(adr(idx), d, r);
    chk({30'h0, r}, 32'h0000_0000);
    chk(d, exp);
  endtask

  task automatic pins_chk(input logic [15:0] oe, input logic [15:0] pu);
    @(negedge aclk);
    chk({16'h0, pin_oe}, {16'h0, oe});
    chk({16'h0, pin_pullup_en}, {16'h0, pu});
  endtask

  task automatic reset_state;
    rd_chk(gpio_pkg::GROUP_DIRECTION_CONTROL, 32'h0000_0000);
    rd_chk(gpio_pkg::GROUP_PULLUP_CONTROL, 32'h0000_0000);
    pins_chk(16'h0000, 16'hffff);
  endtask

  task automatic direction_and_data;
    logic [1:0] r;
    wr(adr(gpio_pkg::PIN_GROUP0_DATA), 32'h0000_0009, r);
    wr(adr(gpio_pkg::PIN_GROUP2_DATA), 32'h0000_0006, r);
    // group 1 stays an input; its stored bits must not reach the pins
    wr(adr(gpio_pkg::PIN_GROUP1_DATA), 32'h0000_000c, r);
    pins_chk(16'h0000, 16'hffff);
    wr(adr(gpio_pkg::GROUP_DIRECTION_CONTROL), 32'h0000_0005, r);
    chk({30'h0, r}, 32'h0000_0000);
    pins_chk(16'h0f0f, 16'hffff);
    chk({28'h0, pin_out[3:0]}, 32'h0000_0009);
    chk({28'h0, pin_out[11:8]}, 32'h0000_0006);
    rd_chk(gpio_pkg::GROUP_DIRECTION_CONTROL, 32'h0000_0005);
    rd_chk(gpio_pkg::PIN_GROUP0_DATA, 32'h0000_0009);
    rd_chk(gpio_pkg::PIN_GROUP2_DATA, 32'h0000_0006);
    wr(adr(gpio_pkg::GROUP_DIRECTION_CONTROL), 32'h0000_0000, r);
    pins_chk(16'h0000, 16'hffff);
  endtask

  task automatic pullup_and_level;
    logic [1:0] r;
    wr(adr(gpio_pkg::GROUP_PULLUP_CONTROL), 32'h0000_000a, r);
    pins_chk(16'h0000, 16'h0f0f);
    rd_chk(gpio_pkg::GROUP_PULLUP_CONTROL, 32'h0000_000a);
    @(posedge aclk);
    ext_drv <= 16'h0030;
    ext_en <= 16'h00f0;
    // group 0 is pulled up, group 1 is driven from the board
    @(negedge aclk);
    chk({24'h0, mem_in}, 32'h0000_003f);
    rd_chk(gpio_pkg::PIN_GROUP1_DATA, 32'h0000_0003);
    @(posedge aclk);
    ext_en <= 16'h0000;
    wr(adr(gpio_pkg::GROUP_PULLUP_CONTROL), 32'h0000_0000, r);
    rd_chk(gpio_pkg::PIN_GROUP3_DATA, 32'h0000_000f);
  endtask

  task automatic unmapped_access;
    logic [31:0] d;
    logic [1:0] r;
    rd(14'h0000, d, r);
    chk({30'h0, r}, {30'h0, gpio_pkg::RESP_SLVERR});
    chk(d, 32'h0000_0000);
    wr(14'h0004, 32'h0000_000f, r);
    chk({30'h0, r}, {30'h0, gpio_pkg::RESP_SLVERR});
    // lane 0 strobe low: answered but nothing stored
    wstrb <= 4'h0;
    wr(adr(gpio_pkg::GROUP_DIRECTION_CONTROL), 32'h0000_000f, r);
    wstrb <= 4'hf;
    chk({30'h0, r}, 32'h0000_0000);
    rd_chk(gpio_pkg::GROUP_DIRECTION_CONTROL, 32'h0000_0000);
  endtask

  task automatic test_done;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    reset_state();
    direction_and_data();
    pullup_and_level();
    unmapped_access();
    test_done();
  end

  // the whole sequence needs well under a thousand cycles
  initial
  begin
    repeat (5000) @(posedge aclk);
    num_errors++;
    test_done();
  end
endmodule
